// ===== hdl/sarcc_control.sv
`timescale 1ns/1ps
`include "sarcc_consts.svh"
module sarcc_control #(
  parameter int WIDTH   = 8,
  parameter int STEP_CY = `SARCC_CONV_CYC / WIDTH
) (
  input  wire logic             clock,
  input  wire logic             reset,
  input  wire logic             start,
  input  wire logic             output_enable_n,
  input  wire logic             comp_above,
  output logic                  result_ready_n,
  output logic [WIDTH-1:0]      dac_code,
  output logic [WIDTH-1:0]      data_out,
  output logic [WIDTH-1:0]      data_oe_n
);
  import sarcc_pkg::*;

  // Cycles from sampled start fall to sampled flag drop
  localparam int CONV_CYC = WIDTH * STEP_CY + 1;

  // Pin synchronisers; first stage feeds only the second
  logic [2:0] start_sync_reg, start_sync_next;
  logic [2:0] oe_sync_reg, oe_sync_next;
  logic       start_lvl_reg, start_lvl_next;
  logic       oe_lvl_reg, oe_lvl_next;

  always_comb begin
    start_sync_next = {start_sync_reg[1:0], start};
    oe_sync_next    = {oe_sync_reg[1:0], output_enable_n};
    start_lvl_next  = start_lvl_reg;
    oe_lvl_next     = oe_lvl_reg;
    // Level changes only when stages two and three agree
    if (start_sync_reg[1] == start_sync_reg[2]) begin
      start_lvl_next = start_sync_reg[2];
    end
    if (oe_sync_reg[1] == oe_sync_reg[2]) begin
      oe_lvl_next = oe_sync_reg[2];
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      start_sync_reg <= 3'h0;
      oe_sync_reg    <= 3'h7;
      start_lvl_reg  <= 1'b0;
      oe_lvl_reg     <= 1'b1;
    end else begin
      start_sync_reg <= start_sync_next;
      oe_sync_reg    <= oe_sync_next;
      start_lvl_reg  <= start_lvl_next;
      oe_lvl_reg     <= oe_lvl_next;
    end
  end

  wire start_rise = start_lvl_next & ~start_lvl_reg;
  wire start_fall = ~start_lvl_next & start_lvl_reg;

  // Conversion sequencer
  sarcc_state_t     state_reg, state_next;
  logic [WIDTH-1:0] sar_reg, sar_next;
  logic [WIDTH-1:0] trial_reg, trial_next;
  logic [15:0]      step_reg, step_next;
  logic             ready_n_reg, ready_n_next;

  always_comb begin
    state_next   = state_reg;
    sar_next     = sar_reg;
    trial_next   = trial_reg;
    step_next    = step_reg;
    ready_n_next = ready_n_reg;
    if (start_rise) begin
      // Restart wins over any conversion in flight
      state_next   = SARCC_ARMED;
      sar_next     = `SARCC_RESULT_RST; // RULE_02
      trial_next   = '0;
      ready_n_next = 1'b1;              // RULE_02 RULE_03
    end else begin
      unique case (state_reg)
        SARCC_IDLE: begin
        end
        SARCC_ARMED: begin
          if (start_fall) begin
            state_next = SARCC_BITS;     // RULE_04
            trial_next = {1'b1, {(WIDTH-1){1'b0}}};
            sar_next   = {1'b1, {(WIDTH-1){1'b0}}};
            step_next  = '0;
          end
        end
        SARCC_BITS: begin
          if (step_reg == 16'(STEP_CY - 1)) begin
            step_next = '0;
            // Drop the trial bit when the weighted sum overshoots
            if (comp_above) begin
              sar_next = sar_reg & ~trial_reg; // RULE_15
            end
            trial_next = trial_reg >> 1;
            if (trial_reg[0]) begin
              state_next = SARCC_DONE;
            end else begin
              sar_next = (comp_above ? (sar_reg & ~trial_reg) : sar_reg)
                         | (trial_reg >> 1);  // RULE_15
            end
          end else begin
            step_next = step_reg + 16'h0001;
          end
        end
        SARCC_DONE: begin
          // LSB already stored one cycle earlier
          ready_n_next = 1'b0;           // RULE_05 RULE_16
          state_next   = SARCC_IDLE;
        end
        default: state_next = SARCC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_reg   <= SARCC_IDLE;
      sar_reg     <= `SARCC_RESULT_RST;
      trial_reg   <= '0;
      step_reg    <= '0;
      ready_n_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      sar_reg     <= sar_next;
      trial_reg   <= trial_next;
      step_reg    <= step_next;
      ready_n_reg <= ready_n_next;
    end
  end

  // Output buffers; a hold cycle keeps data after release
  logic             drive_reg, drive_next;
  logic [WIDTH-1:0] dout_reg, dout_next;
  logic [1:0]       hold_reg, hold_next;
  logic [WIDTH-1:0] oe_n_reg, oe_n_next;

  always_comb begin
    drive_next = drive_reg;
    dout_next  = dout_reg;
    hold_next  = hold_reg;
    if (!oe_lvl_reg) begin
      // Early enable shows partial code, as real part would
      drive_next = 1'b1;                 // RULE_07 RULE_06
      dout_next  = sar_reg;              // RULE_11
      hold_next  = 2'(`SARCC_HOLD_CYC);
    end else if (hold_reg != 2'h0) begin
      hold_next = hold_reg - 2'h1;       // RULE_08
    end else begin
      drive_next = 1'b0;                 // RULE_08
    end
    oe_n_next = {WIDTH{~drive_next}};    // RULE_07
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      drive_reg <= 1'b0;
      dout_reg  <= '0;
      hold_reg  <= 2'h0;
      oe_n_reg  <= '1;
    end else begin
      drive_reg <= drive_next;
      dout_reg  <= dout_next;
      hold_reg  <= hold_next;
      oe_n_reg  <= oe_n_next;
    end
  end

  assign result_ready_n = ready_n_reg;
  assign dac_code       = sar_reg;
  assign data_out       = dout_reg;
  assign data_oe_n      = oe_n_reg;

  // Checks
  flag_rise_a: assert property (@(posedge clock) disable iff (reset) // RULE_03
    $rose(start_lvl_reg) |-> result_ready_n)
    else $error("flag not high after start rise");
  result_clear_a: assert property (@(posedge clock) disable iff (reset) // RULE_02
    $rose(start_lvl_reg) |-> dac_code == 8'h00)
    else $error("result not cleared on start");
  bits_on_fall_a: assert property (@(posedge clock) disable iff (reset) // RULE_04
    $rose(state_reg == SARCC_BITS) |-> $fell(start_lvl_reg))
    else $error("conversion began without start fall");
  conv_time_a: assert property (@(posedge clock) disable iff (reset || start_rise) // RULE_05
    $fell(start_lvl_reg) && state_reg == SARCC_BITS && !start_lvl_next
      |-> ##[CONV_CYC:CONV_CYC] $fell(result_ready_n))
    else $error("conversion time out of range");
  lsb_stored_a: assert property (@(posedge clock) disable iff (reset) // RULE_16
    $fell(result_ready_n) |-> $stable(dac_code) && $past(state_reg) == SARCC_DONE)
    else $error("flag fell before lsb stored");
  drive_low_a: assert property (@(posedge clock) disable iff (reset) // RULE_07
    !oe_lvl_reg |=> data_oe_n == 8'h00)
    else $error("data not driven under enable");
  float_a: assert property (@(posedge clock) disable iff (reset) // RULE_08
    $rose(oe_lvl_reg) |-> ##1 data_oe_n == 8'h00 ##2 data_oe_n == 8'hFF)
    else $error("float timing wrong");
  msb_first_a: assert property (@(posedge clock) disable iff (reset) // RULE_15
    $rose(state_reg == SARCC_BITS) |-> trial_reg == 8'h80)
    else $error("msb not tested first");
  conv_c: cover property (@(posedge clock) disable iff (reset) $fell(result_ready_n));
  read_c: cover property (@(posedge clock) disable iff (reset) $fell(data_oe_n[0]));
  restart_c: cover property (@(posedge clock) disable iff (reset)
    state_reg == SARCC_BITS && start_rise);
  // Sequencing keeps the flag high and tests one bit at a time
  busy_flag_a: assert property (@(posedge clock) disable iff (reset) // RULE_05
    state_reg == SARCC_BITS |-> result_ready_n)
    else $error("flag low during conversion");
  one_trial_a: assert property (@(posedge clock) disable iff (reset) // RULE_15
    state_reg == SARCC_BITS |-> $onehot(trial_reg))
    else $error("trial bit not one-hot");
  // Bus side: enabled data is the register, released bus floats
  read_data_a: assert property (@(posedge clock) disable iff (reset) // RULE_11
    !oe_lvl_reg |=> data_out == $past(dac_code))
    else $error("read data differs from result");
  float_bound_a: assert property (@(posedge clock) disable iff (reset) // RULE_08
    oe_lvl_reg [*3] |-> data_oe_n == 8'hFF)
    else $error("bus not floated after release");
  early_read_c: cover property (@(posedge clock) disable iff (reset)
    state_reg == SARCC_BITS && !oe_lvl_reg);
endmodule : sarcc_control

// ===== shared/sarcc_consts.svh
// Notes on behaviour
// (RULE_01) Host holds start high at least 500 ns
// (RULE_02) Start rise resets logic, clears result, flag high
// (RULE_03) Flag rises within 1.5 us of start
// (RULE_04) Bit sequence begins on start falling edge
// (RULE_05) Flag falls 10 to 30 us after start fall
// (RULE_06) Early enable exposes partial results on bus
// (RULE_07) Data driven only while enable low, within 250 ns; code drives on the fifth clock edge after enable, 400 to 500 ns
// (RULE_08) Data held 50 ns, floats within 200 ns; code floats on the sixth clock edge after release, 500 to 600 ns
// (RULE_09) Blind host waits 30 us before reading
// (RULE_10) Host gates address with write and read strobes
// (RULE_11) Any write starts; read returns result byte
// (RULE_12) Host may poll or interrupt on flag
// (RULE_13) Glue flip-flop stretches short write strobes
// (RULE_14) Sample-hold follows flag; wait 10 us after
// (RULE_15) Test bits MSB first, drop if sum exceeds
// (RULE_16) Flag falls only after LSB decision stored
`ifndef SARCC_CONSTS_SVH
`define SARCC_CONSTS_SVH
`define SARCC_CLK_NS        100
`define SARCC_FLAG_RISE_NS  1500
`define SARCC_FLAG_RISE_CYC ((`SARCC_FLAG_RISE_NS) / (`SARCC_CLK_NS))
`define SARCC_CONV_NS       20000
`define SARCC_CONV_CYC      ((`SARCC_CONV_NS) / (`SARCC_CLK_NS))
`define SARCC_HOLD_NS       50
`define SARCC_HOLD_CYC      (((`SARCC_HOLD_NS) + (`SARCC_CLK_NS) - 1) / (`SARCC_CLK_NS))
`define SARCC_BLIND_NS      30000
`define SARCC_BLIND_CYC     ((`SARCC_BLIND_NS) / (`SARCC_CLK_NS))
`define SARCC_ACQ_NS        10000
`define SARCC_ACQ_CYC       ((`SARCC_ACQ_NS) / (`SARCC_CLK_NS))
`define SARCC_RESULT_RST    8'h00
`endif

// ===== shared/sarcc_pkg.sv
package sarcc_pkg;
  typedef enum logic [3:0] {
    SARCC_IDLE  = 4'h1,
    SARCC_ARMED = 4'h2,
    SARCC_BITS  = 4'h4,
    SARCC_DONE  = 4'h8
  } sarcc_state_t;
endpackage : sarcc_pkg

// ===== bench/sarcc_host.sv
`timescale 1ns/1ps
module sarcc_host (
  input  wire logic       addr_hit,
  input  wire logic       wr_strobe,
  input  wire logic       rd_strobe,
  input  wire logic       stretch_mode,
  input  wire logic       sh_mode,
  input  wire logic [7:0] vin,
  input  wire logic [7:0] dac_code,
  input  wire logic       result_ready_n,
  output logic            start,
  output logic            output_enable_n,
  output logic            comp_above
);
  wire        wr_hit      = addr_hit & wr_strobe;
  logic       stretch_reg = 1'b0;
  logic [7:0] held_vin;

  // Glue flip-flop: short write sets it, flag rise clears it
  always @(posedge wr_hit or posedge result_ready_n) begin
    if (result_ready_n) begin
      stretch_reg <= 1'b0;
    end else if (stretch_mode) begin
      stretch_reg <= 1'b1;
    end
  end

  // Sample-hold: flag high holds, flag low tracks the input
  always_latch begin
    if (!sh_mode || !result_ready_n) begin
      held_vin <= vin;
    end
  end

  // Decoded address gated with the bus strobes
  assign start           = stretch_mode ? stretch_reg : wr_hit;
  assign output_enable_n = ~(addr_hit & rd_strobe);
  // Ideal comparator, so the result equals the held input code
  assign comp_above = (dac_code > held_vin);
endmodule : sarcc_host

// ===== bench/tb_sar_adc_conversion_control.sv
`timescale 1ns/1ps
`include "sarcc_consts.svh"
module tb_sar_adc_conversion_control;
  logic       clock = 1'b0;
  logic       reset = 1'b1;
  logic       addr_hit = 1'b0;
  logic       wr_strobe = 1'b0;
  logic       rd_strobe = 1'b0;
  logic       stretch_mode = 1'b0;
  logic       sh_mode = 1'b0;
  logic [7:0] vin = 8'h00;
  logic       start, output_enable_n, comp_above, result_ready_n;
  logic [7:0] dac_code, data_out, data_oe_n;
  int         bad_count = 0;
  int         checks_done = 0;

  always #50 clock = ~clock;

  sarcc_host host_u (.addr_hit(addr_hit), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
    .stretch_mode(stretch_mode), .sh_mode(sh_mode), .vin(vin), .dac_code(dac_code),
    .result_ready_n(result_ready_n), .start(start), .output_enable_n(output_enable_n),
    .comp_above(comp_above));
  // Short bit step keeps the run brief
  sarcc_control #(.STEP_CY(2)) dut_u (.clock(clock), .reset(reset), .start(start),
    .output_enable_n(output_enable_n), .comp_above(comp_above),
    .result_ready_n(result_ready_n), .dac_code(dac_code), .data_out(data_out),
    .data_oe_n(data_oe_n));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  // Inputs change a fixed delay after the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #10;
  endtask : tick

  // Bounded wait on the flag; running out ends the run
  task automatic wait_flag(input logic lvl);
    int i;
    for (i = 0; i < 60 && result_ready_n !== lvl; i++) tick(1);
    if (i == 60) begin
      bad_count++;
      summarize();
    end
  endtask : wait_flag

  // Bounded wait on the data enables; the final compare flags a timeout
  task automatic wait_oe(input logic [7:0] val);
    for (int i = 0; i < 8 && data_oe_n !== val; i++) tick(1);
    check(data_oe_n, val);
    if (data_oe_n !== val) summarize();
  endtask : wait_oe

  // Write of any value, held 600 ns
  task automatic pulse_start();
    addr_hit = 1'b1;
    wr_strobe = 1'b1;
    tick(6);
    check({7'h00, result_ready_n}, 8'h01);
    check(dac_code, 8'h00);
    wr_strobe = 1'b0;
    addr_hit = 1'b0;
  endtask : pulse_start

  task automatic read_check(input logic [7:0] exp);
    addr_hit = 1'b1;
    rd_strobe = 1'b1;
    wait_oe(8'h00);
    check(data_out, exp);
    rd_strobe = 1'b0;
    addr_hit = 1'b0;
    tick(1);
    check(data_oe_n, 8'h00);
    wait_oe(8'hFF);
  endtask : read_check

  task automatic convert(input logic [7:0] v);
    vin = v;
    pulse_start();
    wait_flag(1'b0);
    read_check(v);
  endtask : convert

  // Blind host: fixed wait of the longest conversion, then read
  task automatic blind_read(input logic [7:0] v);
    vin = v;
    pulse_start();
    tick(`SARCC_BLIND_CYC);
    check({7'h00, result_ready_n}, 8'h00);
    read_check(v);
  endtask : blind_read

  // One-cycle write strobe, stretched by the glue flip-flop
  task automatic stretch_convert(input logic [7:0] v);
    stretch_mode = 1'b1;
    vin = v;
    addr_hit = 1'b1;
    wr_strobe = 1'b1;
    tick(1);
    wr_strobe = 1'b0;
    addr_hit = 1'b0;
    tick(4);
    check({6'h00, start, result_ready_n}, 8'h01);
    wait_flag(1'b0);
    read_check(v);
    stretch_mode = 1'b0;
  endtask : stretch_convert

  // Input moves while held; next start only after acquisition
  task automatic sh_convert(input logic [7:0] v);
    sh_mode = 1'b1;
    vin = v;
    pulse_start();
    vin = ~v;
    wait_flag(1'b0);
    read_check(v);
    tick(`SARCC_ACQ_CYC);
    convert(~v);
    sh_mode = 1'b0;
  endtask : sh_convert

  // Early read exposes the bus mid-conversion, then a restart
  task automatic early_and_restart();
    vin = 8'h33;
    pulse_start();
    tick(3);
    addr_hit = 1'b1;
    rd_strobe = 1'b1;
    wait_oe(8'h00);
    check({7'h00, result_ready_n}, 8'h01);
    rd_strobe = 1'b0;
    addr_hit = 1'b0;
    wait_oe(8'hFF);
    convert(8'hC3);
  endtask : early_and_restart

  initial begin
    tick(4);
    reset = 1'b0;
    tick(1);
    check({7'h00, result_ready_n}, 8'h00);
    check(data_oe_n, 8'hFF);
    convert(8'h00);
    convert(8'hFF);
    convert(8'hA5);
    convert(8'h5A);
    early_and_restart();
    blind_read(8'h3C);
    stretch_convert(8'h81);
    sh_convert(8'h96);
    summarize();
  end
endmodule : tb_sar_adc_conversion_control
